// >>> pbt_slave.sv
// Pipelined bus transfer slave with a small word store
//
// Contract
// - Master requests and waits for grant first
// - One address cycle then data cycles
// - Slave captures address in address cycle
// - Ready low inserts one wait cycle
// - OKAY with ready high means success
// - ERROR answer when transfer fails
// - RETRY or SPLIT means master retries
// - Broken burst is re-arbitrated then finished
// - Address driven, sampled, response sampled next
// - Address phase overlaps previous data phase
// - Read data valid only at completion
// - Waits also stretch next address phase
// - IDLE ignored, zero-wait OKAY answer
// - BUSY ignored, zero-wait OKAY answer
// - Separate write and read data buses
`default_nettype none

module pbt_slave
  import pbt_pkg::*;
#(
  parameter int MEM_WORDS = 256  // Words held in the store
)(
  input  wire logic              clk_i,        // Bus clock
  input  wire logic              rst_b_i,      // Asynchronous reset, active low
  input  wire logic              sel_i,        // Slave selected by decoder
  input  wire logic [ADDR_W-1:0] addr_i,       // Transfer address
  input  wire logic [1:0]        trans_i,      // Transfer type
  input  wire logic              write_i,      // High for write
  input  wire logic [2:0]        size_i,       // Transfer size code
  input  wire logic [DATA_W-1:0] wdata_i,      // Write data bus
  input  wire logic              ready_i,      // Bus-wide ready in
  input  wire logic [WAIT_W-1:0] wait_cfg_i,   // Wait states per transfer
  input  wire logic              err_cfg_i,    // Answer ERROR to writes
  input  wire logic              retry_cfg_i,  // Answer RETRY to reads
  output var  logic              ready_o,      // Slave ready out
  output var  logic [1:0]        resp_o,       // Response code
  output var  logic [DATA_W-1:0] rdata_o,      // Read data bus
  output var  logic              done_o        // Pulse per data transfer finished with OKAY
);

  // ****************************************************************
  // Address phase capture
  // ****************************************************************

  // A transfer is accepted only while the bus shows ready; the address
  // phase is stretched by waits so it is sampled in that single ready cycle
  logic              take;        // Real transfer accepted this edge
  logic              take_void;   // IDLE or BUSY accepted this edge
  logic              act;         // Data phase of a real transfer pending
  logic [ADDR_W-1:0] addr_q;      // Captured address
  logic              write_q;     // Captured direction
  logic [2:0]        size_q;      // Captured size
  pbt_state_type     state;       // Data phase state
  logic [WAIT_W-1:0] wait_cnt;    // Remaining wait cycles
  logic [DATA_W-1:0] mem [MEM_WORDS];  // Word store

  assign take      = sel_i && ready_i && trans_i[1];
  assign take_void = sel_i && ready_i && !trans_i[1];

  // Byte lane mask for a write of given size at given address
  function automatic logic [3:0] lane_mask(input logic [2:0] sz, input logic [1:0] a);
    logic [3:0] m;
    m = 4'hF;
    if (sz == 3'h0)
    begin
      m = 4'(4'h1 << a);
    end
    else if (sz == 3'h1)
    begin
      m = a[1] ? 4'hC : 4'h3;
    end
    return m;
  endfunction

  // Word index in the store
  function automatic logic [MEM_AW-1:0] word_idx(input logic [ADDR_W-1:0] a);
    return a[MEM_AW+1:2];
  endfunction

  // Captures address and control only on an accepted address cycle
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      addr_q  <= '0;
      write_q <= 1'b0;
      size_q  <= 3'h0;
    end
    else if (take)
    begin
      addr_q  <= addr_i;
      write_q <= write_i;
      size_q  <= size_i;
    end
  end

  // ****************************************************************
  // Data phase sequencing
  // ****************************************************************

  // Waits, then answers; ERROR and RETRY take two cycles so the master
  // sees the code before ready rises and can cancel its next address
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state    <= ST_IDLE;
      wait_cnt <= WAIT_RESET;
      act      <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE, ST_RESP2:
        begin
          // New address phase is taken only when the previous one ended
          if (take)
          begin
            act      <= 1'b1;
            wait_cnt <= wait_cfg_i;
            if (wait_cfg_i != '0)
            begin
              state <= ST_WAIT;
            end
            else if ((write_i && err_cfg_i) || (!write_i && retry_cfg_i))
            begin
              state <= ST_RESP1;
            end
            else
            begin
              state <= ST_IDLE;
            end
          end
          else
          begin
            act   <= 1'b0;
            state <= ST_IDLE;
          end
        end
        ST_WAIT:
        begin
          // Each low ready cycle adds one clock to the data phase
          wait_cnt <= wait_cnt - 1'b1;
          if (wait_cnt == 4'h1)
          begin
            if ((write_q && err_cfg_i) || (!write_q && retry_cfg_i))
            begin
              state <= ST_RESP1;
            end
            else
            begin
              state <= ST_IDLE;
            end
          end
        end
        ST_RESP1:
        begin
          state <= ST_RESP2;
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Response outputs
  // ****************************************************************

  logic             next_ready;  // Ready for the coming cycle
  logic [1:0]       next_resp;   // Response for the coming cycle
  logic             fin;         // Data phase of a real transfer ends now

  // Decides what the next cycle shows; registered so the outputs come
  // from flip-flops, which costs a lookahead on the same conditions
  always_comb
  begin
    next_ready = 1'b1;
    next_resp  = RESP_OKAY;
    if (state == ST_RESP1)
    begin
      next_resp = write_q ? RESP_ERROR : RESP_RETRY;
    end
    else if ((state == ST_IDLE || state == ST_RESP2) && take)
    begin
      if (wait_cfg_i != '0)
      begin
        next_ready = 1'b0;
      end
      else if ((write_i && err_cfg_i) || (!write_i && retry_cfg_i))
      begin
        next_ready = 1'b0;
        next_resp  = write_i ? RESP_ERROR : RESP_RETRY;
      end
    end
    else if (state == ST_WAIT && wait_cnt != 4'h1)
    begin
      next_ready = 1'b0;
    end
    else if (state == ST_WAIT &&
             ((write_q && err_cfg_i) || (!write_q && retry_cfg_i)))
    begin
      next_ready = 1'b0;
      next_resp  = write_q ? RESP_ERROR : RESP_RETRY;
    end
  end

  // Registers ready and response
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ready_o <= 1'b1;
      resp_o  <= RESP_OKAY;
    end
    else
    begin
      ready_o <= next_ready;
      resp_o  <= next_resp;
    end
  end

  // Successful completion: pending real transfer, ready high, OKAY
  assign fin = act && ready_o && resp_o == RESP_OKAY && state == ST_IDLE;

  // ****************************************************************
  // Data movement
  // ****************************************************************

  logic [3:0]        wr_lanes;   // Byte lanes of the finishing write
  logic [DATA_W-1:0] lane_bits;  // Same lanes as a bit mask
  logic [DATA_W-1:0] rd_word;    // Addressed word, finishing write merged in

  // A read taken as the previous write finishes must see that write, which
  // only reaches the store at this same edge
  assign wr_lanes  = lane_mask(size_q, addr_q[1:0]);
  assign lane_bits = {{8{wr_lanes[3]}}, {8{wr_lanes[2]}}, {8{wr_lanes[1]}}, {8{wr_lanes[0]}}};
  assign rd_word   = (fin && write_q && word_idx(addr_q) == word_idx(addr_i)) ?
                     ((mem[word_idx(addr_i)] & ~lane_bits) | (wdata_i & lane_bits)) :
                     mem[word_idx(addr_i)];

  // Write data is taken at completion; the master holds it meanwhile
  always_ff @(posedge clk_i)
  begin
    if (fin && write_q)
    begin
      mem[word_idx(addr_q)] <= (mem[word_idx(addr_q)] & ~lane_bits) | (wdata_i & lane_bits);
    end
  end

  // Read data is loaded for the completing cycle and held until the next read completes
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rdata_o <= RDATA_RESET;
    end
    else if (!next_ready || next_resp != RESP_OKAY)
    begin
      rdata_o <= rdata_o;
    end
    else if (take && !write_i && state != ST_WAIT)
    begin
      rdata_o <= rd_word;
    end
    else if (state == ST_WAIT && !write_q)
    begin
      rdata_o <= mem[word_idx(addr_q)];
    end
  end

  // Completion pulse, one cycle per transfer finished with OKAY
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= fin;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************

  sequence s_err_first;
    !ready_o && resp_o != RESP_OKAY;
  endsequence
  sequence s_err_second;
    ready_o && resp_o == $past(resp_o);
  endsequence
  a_void_zero_wait : assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (take_void && (state == ST_IDLE || state == ST_RESP2)) |=> ready_o && resp_o == RESP_OKAY)
    else $error("Idle or busy cycle not answered with zero-wait okay");
  a_wait_count : assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ((state == ST_IDLE || state == ST_RESP2) && take && wait_cfg_i == 4'h2 && !err_cfg_i
     && !retry_cfg_i) |=> !ready_o ##1 !ready_o ##1 ready_o)
    else $error("Wait state count differs from setting");
  a_two_cycle_err : assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (s_err_first) |=> s_err_second)
    else $error("Error or retry answer not two cycles");
  a_err_code : assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (s_err_first) |-> resp_o == (write_q ? RESP_ERROR : RESP_RETRY))
    else $error("Wrong failing response code");
  a_okay_low : assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!ready_o && resp_o == RESP_OKAY) |-> state == ST_WAIT)
    else $error("Ready low with okay outside waits");
  a_done_pulse : assert property (@(posedge clk_i) disable iff (!rst_b_i)
    done_o |-> $past(act) && $past(ready_o))
    else $error("Completion without accepted transfer");
  a_addr_hold : assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!ready_o) |=> $stable(addr_q))
    else $error("Captured address changed in data phase");
  a_read_valid : assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!ready_o && resp_o == RESP_OKAY) |-> $stable(rdata_o))
    else $error("Read data moved during wait");

endmodule : pbt_slave

`default_nettype wire

// >>> pbt_pkg.sv
// Package of constants and types for the pipelined bus transfer slave
`default_nettype none

package pbt_pkg;

  // ****************************************************************
  // Transfer type codes
  // ****************************************************************
  localparam logic [1:0] TRANS_IDLE   = 2'h0;  // No transfer wanted
  localparam logic [1:0] TRANS_BUSY   = 2'h1;  // Pause inside a burst
  localparam logic [1:0] TRANS_NONSEQ = 2'h2;  // First beat or single
  localparam logic [1:0] TRANS_SEQ    = 2'h3;  // Later burst beat

  // ****************************************************************
  // Response codes
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY  = 2'h0;  // Normal progress
  localparam logic [1:0] RESP_ERROR = 2'h1;  // Transfer failed
  localparam logic [1:0] RESP_RETRY = 2'h2;  // Try again
  localparam logic [1:0] RESP_SPLIT = 2'h3;  // Split, try again later

  // ****************************************************************
  // Defaults and widths
  // ****************************************************************
  localparam int          ADDR_W      = 32;     // Address bus width
  localparam int          DATA_W      = 32;     // Data bus width
  localparam int          MEM_AW      = 8;      // Word index width of store
  localparam int          WAIT_W      = 4;      // Wait counter width
  localparam logic [3:0]  WAIT_RESET  = 4'h0;   // Default wait states
  localparam logic [31:0] RDATA_RESET = 32'h0;  // Read bus value at reset

  // Two-cycle error and retry answers
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RESP1, ST_RESP2} pbt_state_type;

endpackage : pbt_pkg

`default_nettype wire

// >>> pbt_master_model.sv
// Bus master model that feeds the slave address, control and write data
`default_nettype none

module pbt_master_model
  import pbt_pkg::*;
(
  input  wire logic              clk_i,    // Bus clock
  input  wire logic              ready_i,  // Bus ready
  input  wire logic [1:0]        resp_i,   // Slave response
  input  wire logic [DATA_W-1:0] rdata_i,  // Read data bus
  output var  logic              sel_o,    // Slave select
  output var  logic [ADDR_W-1:0] addr_o,   // Address
  output var  logic [1:0]        trans_o,  // Transfer type
  output var  logic              write_o,  // High for write
  output var  logic [2:0]        size_o,   // Size code
  output var  logic [DATA_W-1:0] wdata_o   // Write data bus
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************
  // Beat state
  // ****************
  logic [31:0] pend_d;     // Data owed by the beat in address phase
  logic        pend_w;     // That beat is a write
  int          waits;      // Low-ready cycles seen last beat
  logic [1:0]  res_resp;   // Response ending the last data phase
  logic [31:0] res_rdata;  // Read data ending the last data phase

  // Bus starts unselected and idle
  initial
  begin
    sel_o   = 1'b0;
    addr_o  = 32'h0;
    trans_o = TRANS_IDLE;
    write_o = 1'b0;
    size_o  = 3'h2;
    wdata_o = 32'h0;
    pend_w  = 1'b0;
    pend_d  = 32'h0;
  end

  // One address phase, overlapping the previous beat's data phase
  task automatic beat(input logic [1:0] t, input logic w, input logic [31:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    sel_o   <= 1'b1;
    trans_o <= t;
    write_o <= w;
    addr_o  <= a;
    size_o  <= 3'h2;
    // Released data bus shows a changing pattern, not stale data
    wdata_o <= pend_w ? pend_d : ~wdata_o;
    pend_w  = w & t[1];
    pend_d  = d;
    @(posedge clk_i);
    // Everything held until ready is sampled high
    while (ready_i !== 1'b1 && n < 64)
    begin
      n++;
      @(posedge clk_i);
    end
    waits     = n;
    res_resp  = resp_i;
    res_rdata = rdata_i;
  endtask

endmodule // pbt_master_model

`default_nettype wire

// >>> pbt_slave_tb_top.sv
// Self-checking bench for the pipelined bus transfer slave
`default_nettype none

module pbt_slave_tb_top
  import pbt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************
  // Wiring
  // ****************
  logic              clk_i;                 // Bus clock
  logic              rst_b_i   = 1'b0;      // Reset, active low
  logic [WAIT_W-1:0] wait_cfg  = 4'h0;      // Wait states
  logic              err_cfg   = 1'b0;      // Fail writes
  logic              retry_cfg = 1'b0;      // Retry reads
  wire logic         sel, wr, ready, done;  // Bus strobes
  wire logic [1:0]   trans, resp;           // Type and response
  wire logic [2:0]   size;                  // Size code
  wire logic [31:0]  addr, wdata, rdata;    // Address and data
  int                err_count  = 0;        // Mismatches
  int                num_checks = 0;        // Comparisons
  int                cyc        = 0;        // Cycles run

  pbt_slave i_pbt_slave (.clk_i(clk_i), .rst_b_i(rst_b_i), .sel_i(sel),
    .addr_i(addr), .trans_i(trans), .write_i(wr), .size_i(size),
    .wdata_i(wdata), .ready_i(ready), .wait_cfg_i(wait_cfg),
    .err_cfg_i(err_cfg), .retry_cfg_i(retry_cfg), .ready_o(ready),
    .resp_o(resp), .rdata_o(rdata), .done_o(done));

  pbt_master_model i_pbt_master_model (.clk_i(clk_i), .ready_i(ready),
    .resp_i(resp), .rdata_i(rdata), .sel_o(sel), .addr_o(addr),
    .trans_o(trans), .write_o(wr), .size_o(size), .wdata_o(wdata));

  // 25 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ****************
  // Helpers
  // ****************
  task automatic close_out();
    if (err_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic bt(input logic [1:0] t, input logic w, input logic [31:0] a);
    i_pbt_master_model.beat(t, w, a, {16'hC0DE, a[15:0]});
  endtask

  // Response and wait count of the data phase just ended
  task automatic res(input logic [1:0] r, input int n);
    chk("resp", {30'h0, r}, {30'h0, i_pbt_master_model.res_resp});
    chk("waits", n, i_pbt_master_model.waits);
  endtask

  // ****************
  // Scenarios
  // ****************
  // Zero-wait write then read of the same word, back to back
  task automatic t_single();
    bt(TRANS_NONSEQ, 1'b1, 32'h10);
    bt(TRANS_NONSEQ, 1'b0, 32'h10);
    res(RESP_OKAY, 0);
    bt(TRANS_IDLE, 1'b0, 32'h0);
    res(RESP_OKAY, 0);
    chk("rdata", 32'hC0DE_0010, i_pbt_master_model.res_rdata);
    @(negedge clk_i);
    chk("done", 32'h1, {31'h0, done});
    @(posedge clk_i);
    bt(TRANS_IDLE, 1'b0, 32'h0);
    res(RESP_OKAY, 0);
  endtask

  // Wrapping write burst, then incrementing read burst with a pause
  task automatic t_burst();
    logic [1:0]  tr[6];
    logic [31:0] ad[6];
    tr = '{TRANS_NONSEQ, TRANS_BUSY, TRANS_SEQ, TRANS_SEQ, TRANS_SEQ, TRANS_IDLE};
    ad = '{32'h40, 32'h44, 32'h44, 32'h48, 32'h4C, 32'h0};
    wait_cfg <= 4'h2;
    for (int i = 0; i < 4; i++)
    begin
      bt(i == 0 ? TRANS_NONSEQ : TRANS_SEQ, 1'b1, 32'h40 | ((32'h4 + 4 * i) & 32'hF));
      if (i > 0)
        res(RESP_OKAY, 2);
    end
    for (int i = 0; i < 6; i++)
    begin
      bt(tr[i], 1'b0, ad[i]);
      if (i == 0 || tr[i - 1] != TRANS_BUSY)
        res(RESP_OKAY, 2);
      else
        res(RESP_OKAY, 0);
      if (i > 0 && tr[i - 1] != TRANS_BUSY)
        chk("rdata", {16'hC0DE, ad[i - 1][15:0]}, i_pbt_master_model.res_rdata);
    end
    wait_cfg <= 4'h0;
  endtask

  // Burst cut after two beats, rebuilt as a new burst, then read back
  task automatic t_break();
    bt(TRANS_NONSEQ, 1'b1, 32'h20);
    bt(TRANS_SEQ, 1'b1, 32'h24);
    bt(TRANS_IDLE, 1'b0, 32'h0);
    bt(TRANS_NONSEQ, 1'b1, 32'h28);
    bt(TRANS_NONSEQ, 1'b0, 32'h24);
    bt(TRANS_NONSEQ, 1'b0, 32'h28);
    res(RESP_OKAY, 0);
    chk("rdata", 32'hC0DE_0024, i_pbt_master_model.res_rdata);
    bt(TRANS_IDLE, 1'b0, 32'h0);
    res(RESP_OKAY, 0);
    chk("rdata", 32'hC0DE_0028, i_pbt_master_model.res_rdata);
  endtask

  // Failed write, then retried read
  task automatic t_fail();
    err_cfg <= 1'b1;
    bt(TRANS_NONSEQ, 1'b1, 32'h80);
    bt(TRANS_IDLE, 1'b0, 32'h0);
    res(RESP_ERROR, 1);
    err_cfg   <= 1'b0;
    retry_cfg <= 1'b1;
    bt(TRANS_NONSEQ, 1'b0, 32'h10);
    bt(TRANS_IDLE, 1'b0, 32'h0);
    res(RESP_RETRY, 1);
    retry_cfg <= 1'b0;
    bt(TRANS_NONSEQ, 1'b0, 32'h10);
    bt(TRANS_IDLE, 1'b0, 32'h0);
    res(RESP_OKAY, 0);
    chk("rdata", 32'hC0DE_0010, i_pbt_master_model.res_rdata);
  endtask

  // ****************
  // Main sequence and hang guard
  // ****************
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_single();
    t_break();
    t_burst();
    t_fail();
    close_out();
  end

  // Whole run needs under a hundred cycles
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      close_out();
    end
  end

endmodule // pbt_slave_tb_top

`default_nettype wire
